//--- rtl/trunk_pkg.sv
// shared constants for the trunk port card and its system side
// assumes one 40 MHz clock for both ends
package trunk_pkg;
  localparam int NPORT = 8;
  localparam int NBUS = 2;
  localparam int NSLOT = 32;
  localparam int SLOT_W = 5;
  localparam int PCLK_HZ = 40_000_000;
  // pcm frame rate and slot spacing
  localparam int FRAME_HZ = 8_000;
  localparam int SLOT_CYC = PCLK_HZ / (FRAME_HZ * NSLOT);
  // tone receiver reference, phase accumulator increment
  localparam longint DTMF_REF_HZ = 3_579_500;
  localparam logic [15:0] DTMF_INC = 16'((DTMF_REF_HZ * 65536) / PCLK_HZ);
  // diagnostic serial rate
  localparam int DIAG_BAUD = 19_200;
  localparam int DIAG_DIV = PCLK_HZ / DIAG_BAUD;
  localparam int DIAG_BITS = 10;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_HOOK = 4'h1,
    CMD_EARTH = 4'h2,
    CMD_LED = 4'h3,
    CMD_TXCFG = 4'h4,
    CMD_LISTEN = 4'h5,
    CMD_POLL = 4'h6,
    CMD_DIAG = 4'h7
  } cmd_e;

  // command argument fields
  localparam int ARG_BUS = 5;
  localparam int ARG_SLOT_LSB = 0;
  // status word fields
  localparam int SW_PORT_LSB = 13;
  localparam int SW_RING = 12;
  localparam int SW_CUR = 11;
  localparam int SW_DIGV = 10;
  localparam int SW_RING_CHG = 9;
  localparam int SW_CUR_CHG = 8;
  localparam int SW_DIG_LSB = 0;

  // system side register map
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_CMD = 12'h004;
  localparam logic [11:0] REG_STAT = 12'h008;
  localparam logic [11:0] REG_RES = 12'h040;
  localparam logic [11:0] REG_SLOT = 12'h100;
  localparam logic [11:0] REG_SLOT_END = 12'h200;
  localparam int CMD_CODE_LSB = 16;
  localparam int CMD_PORT_LSB = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_CNT_LSB = 8;
  localparam int RES_VALID = 16;
endpackage

//--- rtl/trunk_link_if.sv
// link between the trunk card and the system side: pcm buses and command bus
// assumes both ends share pclk
`timescale 1ns/100ps
interface trunk_link_if;
  import trunk_pkg::*;
  // slot timing and listened bus content, system to card
  logic slot_stb;
  logic [SLOT_W-1:0] slot_num;
  logic [NBUS-1:0][7:0] pcm_in;
  // card drive onto the buses
  logic [NBUS-1:0][7:0] pcm_out;
  logic [NBUS-1:0] pcm_oe;
  // command bus
  logic cmd_valid;
  logic [3:0] cmd_code;
  logic [2:0] cmd_port;
  logic [7:0] cmd_arg;
  logic cmd_busy;
  logic rsp_valid;
  logic rsp_last;
  logic [15:0] rsp_word;

  modport card (
    input slot_stb, slot_num, pcm_in, cmd_valid, cmd_code, cmd_port, cmd_arg,
    output pcm_out, pcm_oe, cmd_busy, rsp_valid, rsp_last, rsp_word
  );
  modport sys (
    output slot_stb, slot_num, pcm_in, cmd_valid, cmd_code, cmd_port, cmd_arg,
    input pcm_out, pcm_oe, cmd_busy, rsp_valid, rsp_last, rsp_word
  );
endinterface

//--- rtl/trunk_card.sv
// eight-port trunk card: per-port status, pcm slot exchange, polled events
// assumes system side drives slot timing and commands on the link
// Overview of operation
// [RL1] eight independent ports with full per-port circuitry
// [RL2] tone receiver yields sixteen digit symbols
// [RL3] tone receivers share one 3.5795 MHz reference
// [RL4] earth relay grounds the B lead
// [RL5] software sets port off-hook before calls
// [RL6] ring indication forwarded for answering calls
// [RL7] ring always valid; current only off-hook
// [RL8] normal loop current reads low
// [RL9] wink reads high for its duration
// [RL10] codec path converts samples both ways
// [RL11] each port listens any slot, either bus
// [RL12] ports transmit in eight consecutive slots
// [RL13] selected slot sample delivered to codec
// [RL14] both pcm buses behave identically
// [RL15] transmit bus and slot identify port
// [RL16] all ports polled in turn for events
// [RL17] poll reports every change since last
// [RL18] commands in, status out, same bus
// [RL19] three panel indicators from register
// [RL20] asynchronous diagnostic serial line
// [RL21] reported changes cleared after delivery
// [RL22] one byte per frame per slot
`timescale 1ns/100ps
module trunk_card #(
  parameter int DIAG_CYC = trunk_pkg::DIAG_DIV
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link to system side
  trunk_link_if.card link,
  // line detectors
  input wire logic [trunk_pkg::NPORT-1:0] ring_det,
  input wire logic [trunk_pkg::NPORT-1:0] cur_det,
  input wire logic [trunk_pkg::NPORT-1:0] dtmf_stb,
  input wire logic [trunk_pkg::NPORT-1:0][3:0] dtmf_digit,
  // codec paths
  input wire logic [trunk_pkg::NPORT-1:0][7:0] codec_tx,
  output logic [trunk_pkg::NPORT-1:0][7:0] codec_rx,
  output logic [trunk_pkg::NPORT-1:0] codec_rx_stb,
  // relays and reference
  output logic [trunk_pkg::NPORT-1:0] hook_relay,
  output logic [trunk_pkg::NPORT-1:0] b_lead_gnd,
  output logic dtmf_ref_clk,
  // panel and diagnostics
  output logic led_red,
  output logic led_yellow,
  output logic led_green,
  output logic diag_txd
);
  import trunk_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SCAN = 2'b01,
    ST_END = 2'b10
  } card_st_e;

  typedef struct packed {
    card_st_e st;
    logic busy;
    logic [2:0] scan;
    logic [3:0] cnt;
    logic [NPORT-1:0] hook;
    logic [NPORT-1:0] earth;
    logic [2:0] led;
    logic tx_bus;
    logic [SLOT_W-1:0] tx_base;
    logic [NPORT-1:0] lis_bus;
    logic [NPORT-1:0][SLOT_W-1:0] lis_slot;
    logic [NBUS-1:0][7:0] pcm_out;
    logic [NBUS-1:0] pcm_oe;
    logic [NPORT-1:0][7:0] rx;
    logic [NPORT-1:0] rx_stb;
    logic [NPORT-1:0] ring;
    logic [NPORT-1:0] cur;
    logic [NPORT-1:0] ring_chg;
    logic [NPORT-1:0] cur_chg;
    logic [NPORT-1:0] dig_pend;
    logic [NPORT-1:0][3:0] digit;
    logic rsp_valid;
    logic rsp_last;
    logic [15:0] rsp_word;
    logic [15:0] ref_acc;
    logic [DIAG_BITS-1:0] tx_sh;
    logic [3:0] tx_left;
    logic [15:0] tx_div;
  } card_s;

  card_s s_q, s_d;

  function automatic logic [SLOT_W-1:0] port_slot(input logic [SLOT_W-1:0] base,
                                                  input int p);
    port_slot = SLOT_W'(base + SLOT_W'(p));
  endfunction

  function automatic logic [15:0] status_word(input card_s s, input int p);
    status_word = '0;
    status_word[SW_PORT_LSB +: 3] = 3'(p);
    status_word[SW_RING] = s.ring[p];
    status_word[SW_CUR] = s.cur[p];
    status_word[SW_DIGV] = s.dig_pend[p];
    status_word[SW_RING_CHG] = s.ring_chg[p];
    status_word[SW_CUR_CHG] = s.cur_chg[p];
    status_word[SW_DIG_LSB +: 4] = s.digit[p];
  endfunction

  always_comb begin
    logic cur_now;
    cur_now = 1'b0;
    s_d = s_q;
    s_d.rsp_valid = 1'b0;
    s_d.rsp_last = 1'b0;
    s_d.rx_stb = '0;
    s_d.ref_acc = s_q.ref_acc + DTMF_INC; // RL3

    // command bus and polling
    case (s_q.st)
      ST_IDLE: begin
        if (link.cmd_valid) begin // RL18
          case (cmd_e'(link.cmd_code))
            CMD_HOOK: s_d.hook[link.cmd_port] = link.cmd_arg[0]; // RL5
            CMD_EARTH: s_d.earth[link.cmd_port] = link.cmd_arg[0];
            CMD_LED: s_d.led = link.cmd_arg[2:0]; // RL19
            CMD_TXCFG: begin
              s_d.tx_bus = link.cmd_arg[ARG_BUS];
              s_d.tx_base = link.cmd_arg[ARG_SLOT_LSB +: SLOT_W];
            end
            CMD_LISTEN: begin
              s_d.lis_bus[link.cmd_port] = link.cmd_arg[ARG_BUS]; // RL11
              s_d.lis_slot[link.cmd_port] = link.cmd_arg[ARG_SLOT_LSB +: SLOT_W];
            end
            CMD_POLL: begin
              s_d.st = ST_SCAN;
              s_d.scan = '0;
              s_d.cnt = '0;
            end
            CMD_DIAG: begin
              if (s_q.tx_left == '0) begin // RL20
                s_d.tx_sh = {1'b1, link.cmd_arg, 1'b0};
                s_d.tx_left = 4'(DIAG_BITS);
                s_d.tx_div = 16'(DIAG_CYC - 1);
              end
            end
            default: ;
          endcase
        end
      end
      ST_SCAN: begin
        if (s_q.ring_chg[s_q.scan] || s_q.cur_chg[s_q.scan] ||
            s_q.dig_pend[s_q.scan]) begin // RL16
          s_d.rsp_valid = 1'b1; // RL17
          s_d.rsp_word = status_word(s_q, int'(s_q.scan));
          s_d.cnt = s_q.cnt + 4'h1;
          s_d.ring_chg[s_q.scan] = 1'b0; // RL21
          s_d.cur_chg[s_q.scan] = 1'b0;
          s_d.dig_pend[s_q.scan] = 1'b0;
        end
        s_d.scan = s_q.scan + 3'h1;
        if (s_q.scan == 3'(NPORT - 1)) begin
          s_d.st = ST_END;
        end
      end
      ST_END: begin
        s_d.rsp_valid = 1'b1;
        s_d.rsp_last = 1'b1;
        s_d.rsp_word = {12'h000, s_q.cnt};
        s_d.st = ST_IDLE;
      end
      default: s_d.st = ST_IDLE;
    endcase
    s_d.busy = (s_d.st != ST_IDLE);

    // detector sampling after clearing, so a new event wins
    for (int p = 0; p < NPORT; p++) begin // RL1
      s_d.ring[p] = ring_det[p]; // RL7
      if (ring_det[p] != s_q.ring[p]) begin
        s_d.ring_chg[p] = 1'b1; // RL6
      end
      cur_now = s_q.hook[p] ? cur_det[p] : 1'b1; // RL7
      s_d.cur[p] = cur_now; // RL8 RL9
      if (s_q.hook[p] && cur_now != s_q.cur[p]) begin
        s_d.cur_chg[p] = 1'b1;
      end
      if (dtmf_stb[p]) begin
        s_d.dig_pend[p] = 1'b1; // RL2
        s_d.digit[p] = dtmf_digit[p];
      end
    end

    // pcm slot exchange, one byte per slot per frame
    if (link.slot_stb) begin // RL22
      for (int b = 0; b < NBUS; b++) begin // RL14
        s_d.pcm_oe[b] = 1'b0;
        for (int p = 0; p < NPORT; p++) begin
          if (s_q.tx_bus == 1'(b) && link.slot_num == port_slot(s_q.tx_base, p)) begin
            s_d.pcm_out[b] = codec_tx[p]; // RL12 RL10
            s_d.pcm_oe[b] = 1'b1;
          end
        end
      end
      for (int p = 0; p < NPORT; p++) begin
        if (link.slot_num == s_q.lis_slot[p]) begin // RL15
          s_d.rx[p] = link.pcm_in[s_q.lis_bus[p]]; // RL13 RL10
          s_d.rx_stb[p] = 1'b1;
        end
      end
    end

    // diagnostic serial shifter, lsb first
    if (s_q.tx_left != '0) begin
      if (s_q.tx_div == '0) begin
        s_d.tx_sh = {1'b1, s_q.tx_sh[DIAG_BITS-1:1]};
        s_d.tx_left = s_q.tx_left - 4'h1;
        s_d.tx_div = 16'(DIAG_CYC - 1);
      end else begin
        s_d.tx_div = s_q.tx_div - 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.cur <= '1;
      s_q.tx_sh <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.pcm_out = s_q.pcm_out;
  assign link.pcm_oe = s_q.pcm_oe;
  assign link.cmd_busy = s_q.busy;
  assign link.rsp_valid = s_q.rsp_valid;
  assign link.rsp_last = s_q.rsp_last;
  assign link.rsp_word = s_q.rsp_word;
  assign codec_rx = s_q.rx;
  assign codec_rx_stb = s_q.rx_stb;
  assign hook_relay = s_q.hook;
  assign b_lead_gnd = s_q.earth; // RL4
  assign dtmf_ref_clk = s_q.ref_acc[15];
  assign {led_red, led_yellow, led_green} = s_q.led;
  assign diag_txd = s_q.tx_sh[0];
endmodule

//--- rtl/trunk_sys.sv
// system side: apb registers, slot timing, bus switch memory, poll results
// assumes an apb master on pclk and the card on the link
`timescale 1ns/100ps
module trunk_sys #(
  parameter int SLOT_CYCLES = trunk_pkg::SLOT_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link to card
  trunk_link_if.sys link
);
  import trunk_pkg::*;

  typedef struct packed {
    logic frame_en;
    logic [15:0] div;
    logic slot_stb;
    logic [SLOT_W-1:0] slot;
    logic [NBUS-1:0][7:0] pcm_in;
    logic [NBUS-1:0][NSLOT-1:0][7:0] ram;
    logic cmd_valid;
    logic [3:0] cmd_code;
    logic [2:0] cmd_port;
    logic [7:0] cmd_arg;
    logic polling;
    logic done;
    logic [3:0] cnt;
    logic [NPORT-1:0] res_v;
    logic [NPORT-1:0][15:0] res;
    logic ready;
    logic err;
    logic [31:0] rdata;
  } sys_s;

  sys_s s_q, s_d;

  always_comb begin
    logic bus_sel;
    logic [SLOT_W-1:0] ram_slot;
    logic [2:0] rp;
    logic [SLOT_W-1:0] nxt;
    bus_sel = paddr[7];
    ram_slot = paddr[6:2];
    rp = paddr[4:2];
    nxt = s_q.slot + 5'h01;
    s_d = s_q;
    s_d.cmd_valid = 1'b0;
    s_d.slot_stb = 1'b0;
    s_d.ready = 1'b0;
    s_d.err = 1'b0;

    // slot timing; capture card drive of the ending slot
    if (s_q.frame_en) begin
      if (s_q.div == '0) begin
        s_d.div = 16'(SLOT_CYCLES - 1);
        s_d.slot_stb = 1'b1;
        s_d.slot = nxt;
        for (int b = 0; b < NBUS; b++) begin
          if (link.pcm_oe[b]) begin
            s_d.ram[b][s_q.slot] = link.pcm_out[b];
          end
          s_d.pcm_in[b] = s_d.ram[b][nxt];
        end
      end else begin
        s_d.div = s_q.div - 16'h0001;
      end
    end

    // responses from a poll
    if (link.rsp_valid) begin
      if (link.rsp_last) begin
        s_d.polling = 1'b0;
        s_d.done = 1'b1;
        s_d.cnt = link.rsp_word[3:0];
      end else begin
        s_d.res[link.rsp_word[SW_PORT_LSB +: 3]] = link.rsp_word;
        s_d.res_v[link.rsp_word[SW_PORT_LSB +: 3]] = 1'b1;
      end
    end

    // apb: decode at setup, answer in the first access cycle
    if (psel && !penable) begin
      s_d.ready = 1'b1;
      s_d.rdata = '0;
      if (paddr == REG_CTRL) begin
        s_d.rdata[0] = s_q.frame_en;
      end else if (paddr == REG_CMD) begin
        s_d.rdata = {12'h000, s_q.cmd_code, 5'h00, s_q.cmd_port, s_q.cmd_arg};
      end else if (paddr == REG_STAT) begin
        s_d.rdata[STAT_BUSY] = s_q.polling | link.cmd_busy | s_q.cmd_valid;
        s_d.rdata[STAT_DONE] = s_q.done;
        s_d.rdata[STAT_CNT_LSB +: 4] = s_q.cnt;
      end else if (paddr[11:5] == REG_RES[11:5] && paddr[1:0] == 2'b00) begin
        s_d.rdata = {15'h0000, s_q.res_v[rp], s_q.res[rp]};
      end else if (paddr >= REG_SLOT && paddr < REG_SLOT_END && paddr[1:0] == 2'b00) begin
        s_d.rdata[7:0] = s_q.ram[bus_sel][ram_slot];
      end else begin
        s_d.err = 1'b1;
      end
    end
    if (psel && penable && s_q.ready && pwrite && !s_q.err) begin
      if (paddr == REG_CTRL) begin
        s_d.frame_en = pwdata[0];
      end else if (paddr == REG_CMD) begin
        if (!(s_q.polling || link.cmd_busy || s_q.cmd_valid)) begin
          s_d.cmd_valid = 1'b1;
          s_d.cmd_code = pwdata[CMD_CODE_LSB +: 4];
          s_d.cmd_port = pwdata[CMD_PORT_LSB +: 3];
          s_d.cmd_arg = pwdata[7:0];
          if (cmd_e'(pwdata[CMD_CODE_LSB +: 4]) == CMD_POLL) begin
            s_d.polling = 1'b1;
            s_d.res_v = '0;
          end
        end
      end else if (paddr == REG_STAT) begin
        if (pwdata[STAT_DONE] && !(link.rsp_valid && link.rsp_last)) begin
          s_d.done = 1'b0;
        end
      end else if (paddr >= REG_SLOT && paddr < REG_SLOT_END) begin
        s_d.ram[bus_sel][ram_slot] = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;
  assign link.slot_stb = s_q.slot_stb;
  assign link.slot_num = s_q.slot;
  assign link.pcm_in = s_q.pcm_in;
  assign link.cmd_valid = s_q.cmd_valid;
  assign link.cmd_code = s_q.cmd_code;
  assign link.cmd_port = s_q.cmd_port;
  assign link.cmd_arg = s_q.cmd_arg;
endmodule

//--- bench/trunk_link_monitor.sv
// concurrent checks on the link between the card and the system side
// assumes one pclk for both ends and a slot period of 4 cycles
`timescale 1ns/100ps
module trunk_link_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pcm slot exchange
  input wire logic slot_stb,
  input wire logic [trunk_pkg::SLOT_W-1:0] slot_num,
  input wire logic [trunk_pkg::NBUS-1:0][7:0] pcm_out,
  input wire logic [trunk_pkg::NBUS-1:0] pcm_oe,
  // command bus
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic cmd_busy,
  input wire logic rsp_valid,
  input wire logic rsp_last,
  input wire logic [15:0] rsp_word
);
  import trunk_pkg::*;
  logic [3:0] rsp_cnt_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence poll_taken;
    cmd_valid && cmd_code == CMD_POLL && !cmd_busy;
  endsequence
  sequence poll_scan;
    cmd_busy [*8];
  endsequence
  sequence slot_gap;
    (!slot_stb && $stable(slot_num)) [*3];
  endsequence

  // port words seen since the poll was taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_cnt_q <= 4'h0;
    end else if (cmd_valid && !cmd_busy) begin
      rsp_cnt_q <= 4'h0;
    end else if (rsp_valid && !rsp_last) begin
      rsp_cnt_q <= rsp_cnt_q + 4'h1;
    end
  end

  AST_POLL_BUSY: assert property (poll_taken |=> poll_scan)
    else $error("poll did not hold busy over the scan");
  AST_POLL_END: assert property (poll_taken |-> ##10 (rsp_valid && rsp_last))
    else $error("end word not 10 cycles after poll");
  AST_END_COUNT: assert property (rsp_valid && rsp_last |-> rsp_word[3:0] == rsp_cnt_q)
    else $error("end word count differs from port words sent");
  AST_LAST_WITH_VALID: assert property (rsp_last |-> rsp_valid)
    else $error("end mark without a response word");
  AST_RSP_IN_POLL: assert property (rsp_valid |-> cmd_busy || $past(cmd_busy))
    else $error("response word outside a poll");
  AST_SLOT_GAP: assert property (slot_stb |=> slot_gap)
    else $error("slot strobe spacing broken");
  AST_SLOT_NEXT: assert property ((slot_stb ##1 slot_gap ##1 slot_stb)
    |-> slot_num == SLOT_W'($past(slot_num) + 1'b1))
    else $error("slot number did not advance by one");
  AST_PCM_HOLD: assert property (!$past(slot_stb) |-> $stable(pcm_out) && $stable(pcm_oe))
    else $error("pcm drive changed inside a slot");
endmodule

//--- bench/trunk_port_pcm_status_bench.sv
// self-checking bench: card and system side joined by the link, apb stimulus
// assumes slot period 4 and serial divider 8 to keep the run short
`timescale 1ns/100ps
module trunk_port_pcm_status_bench;
  import trunk_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, err;
  logic [NPORT-1:0] ring_det = '0, cur_det = '0, dtmf_stb = '0;
  logic [NPORT-1:0][3:0] dtmf_digit = '0;
  logic [NPORT-1:0][7:0] codec_tx = '0, codec_rx;
  logic [NPORT-1:0] codec_rx_stb, hook_relay, b_lead_gnd, hook_m = '0, earth_m = '0;
  logic dtmf_ref_clk, led_red, led_yellow, led_green, diag_txd;
  logic [2:0] led_m = '0;
  logic [31:0] rd;
  int fail_count = 0;
  int checks_done = 0;
  integer seed = 32'hf4864837;

  trunk_link_if link ();
  trunk_card #(.DIAG_CYC(8)) u_trunk_card (.pclk(pclk), .presetn(presetn), .link(link),
    .ring_det(ring_det), .cur_det(cur_det), .dtmf_stb(dtmf_stb), .dtmf_digit(dtmf_digit),
    .codec_tx(codec_tx), .codec_rx(codec_rx), .codec_rx_stb(codec_rx_stb),
    .hook_relay(hook_relay), .b_lead_gnd(b_lead_gnd), .dtmf_ref_clk(dtmf_ref_clk),
    .led_red(led_red), .led_yellow(led_yellow), .led_green(led_green), .diag_txd(diag_txd));
  trunk_sys #(.SLOT_CYCLES(4)) u_trunk_sys (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  trunk_link_monitor u_trunk_link_monitor (.pclk(pclk), .presetn(presetn),
    .slot_stb(link.slot_stb), .slot_num(link.slot_num), .pcm_out(link.pcm_out),
    .pcm_oe(link.pcm_oe), .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code),
    .cmd_busy(link.cmd_busy), .rsp_valid(link.rsp_valid), .rsp_last(link.rsp_last),
    .rsp_word(link.rsp_word));

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; ready and read data taken at the completing rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input cmd_e c, input int p, input logic [7:0] a);
    apb(1'b1, REG_CMD, {12'h0, c, 5'h0, 3'(p), a});
  endtask

  function automatic logic [11:0] slot_addr(input logic b, input logic [4:0] s);
    return REG_SLOT + {4'h0, b, s, 2'b00};
  endfunction

  task automatic wait_outs(input string name);
    logic [31:0] exp;
    exp = {8'h0, led_m, 5'h0, earth_m, hook_m};
    for (int i = 0; i < 20; i++) begin
      if ({8'h0, led_red, led_yellow, led_green, 5'h0, b_lead_gnd, hook_relay} === exp) break;
      @(posedge pclk);
    end
    chk(name, {8'h0, led_red, led_yellow, led_green, 5'h0, b_lead_gnd, hook_relay}, exp);
  endtask

  // clear done, start a poll, leave the final status in rd
  task automatic poll();
    apb(1'b1, REG_STAT, 32'h2);
    cmd(CMD_POLL, 0, 8'h00);
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, REG_STAT, 32'h0);
      if (rd[STAT_DONE] === 1'b1) break;
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    print_verdict();
  end

  initial begin
    int p, q, r, d, n;
    logic tb, ref_q;
    logic [4:0] base, g;
    logic [7:0] v, rm, prev, mask;
    logic [9:0] sframe;
    for (int i = 0; i < NPORT; i++) codec_tx[i] <= 8'($random(seed));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_STAT, 32'h0);
    chk("status after reset", rd, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    wait_outs("outputs after reset");
    for (int k = 0; k < 12; k++) begin
      p = $random(seed) & 7;
      v = 8'($random(seed));
      if (k % 3 == 0) begin
        cmd(CMD_HOOK, p, v);
        hook_m[p] = v[0];
      end else if (k % 3 == 1) begin
        cmd(CMD_EARTH, p, v);
        earth_m[p] = v[0];
      end else begin
        cmd(CMD_LED, p, v);
        led_m = v[2:0];
      end
      wait_outs("relay and panel outputs");
    end
    // transmit block, one listener on the same bus, one on the other bus
    base = 5'($random(seed));
    tb = 1'($random(seed));
    q = $random(seed) & 7;
    r = $random(seed) & 7;
    d = (q + 1) % NPORT;
    g = 5'($random(seed));
    v = 8'($random(seed));
    cmd(CMD_TXCFG, 0, {2'b00, tb, base});
    cmd(CMD_LISTEN, q, {2'b00, tb, 5'(base + 5'(r))});
    cmd(CMD_LISTEN, d, {2'b00, ~tb, g});
    apb(1'b1, slot_addr(~tb, g), {24'h0, v});
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (NSLOT * 4) @(posedge pclk);
    n = 0;
    for (int i = 0; i < 2 * NSLOT * 4; i++) begin
      @(negedge pclk);
      n += int'(codec_rx_stb[q] === 1'b1);
    end
    chk("samples per two frames", 32'(n), 32'd2);
    chk("listen own bus", {24'h0, codec_rx[q]}, {24'h0, codec_tx[r]});
    chk("listen other bus", {24'h0, codec_rx[d]}, {24'h0, v});
    for (int i = 0; i < NPORT; i++) begin
      apb(1'b0, slot_addr(tb, 5'(base + 5'(i))), 32'h0);
      chk("transmit slot byte", {24'h0, rd[7:0]}, {24'h0, codec_tx[i]});
    end
    // events on every digit symbol, then a quiet poll
    cmd(CMD_HOOK, 2, 8'h01);
    hook_m[2] = 1'b1;
    poll();
    prev = '0;
    for (int s = 0; s < 16; s++) begin
      rm = 8'($random(seed));
      d = $random(seed) & 7;
      @(posedge pclk);
      ring_det <= rm;
      cur_det[2] <= ~cur_det[2];
      dtmf_stb[d] <= 1'b1;
      dtmf_digit[d] <= 4'(s);
      @(posedge pclk);
      dtmf_stb <= '0;
      mask = (rm ^ prev) | 8'h04 | (8'h01 << d);
      poll();
      chk("ports reported", {28'h0, rd[STAT_CNT_LSB +: 4]}, 32'($countones(mask)));
      for (int i = 0; i < NPORT; i++) begin
        if (mask[i]) begin
          apb(1'b0, REG_RES + 12'(4 * i), 32'h0);
          chk("result word", rd & 32'h1FF00, {15'h0, 1'b1, 3'(i), rm[i],
            hook_m[i] ? cur_det[i] : 1'b1, i == d, rm[i] ^ prev[i], i == 2, 8'h0});
          if (i == d) chk("digit code", {28'h0, rd[3:0]}, 32'(s));
        end
      end
      prev = rm;
    end
    poll();
    chk("nothing left after report", {28'h0, rd[STAT_CNT_LSB +: 4]}, 32'h0);
    // diagnostic serial frame, sampled mid-bit
    v = 8'($random(seed));
    cmd(CMD_DIAG, 0, v);
    for (int i = 0; i < 40 && diag_txd !== 1'b0; i++) @(posedge pclk);
    repeat (4) @(posedge pclk);
    for (int i = 0; i < DIAG_BITS; i++) begin
      sframe[i] = diag_txd;
      repeat (8) @(posedge pclk);
    end
    chk("serial frame", {22'h0, sframe}, {22'h0, 1'b1, v, 1'b0});
    // reference clock: rising edges over 8192 cycles
    n = 0;
    ref_q = dtmf_ref_clk;
    repeat (8192) begin
      @(posedge pclk);
      n += int'(dtmf_ref_clk === 1'b1 && ref_q === 1'b0);
      ref_q = dtmf_ref_clk;
    end
    chk("reference edges", 32'(n), 32'(DTMF_REF_HZ * 8192 / PCLK_HZ));
    print_verdict();
  end
endmodule
